// [test/psr_ee_model.sv]
// psr_ee_model: behavioural eeprom answering the four-phase word handshake.
// assumes requests change just after mclk edges; answer delay is random.
`timescale 1ns/1ps
module psr_ee_model (
   // handshake
   input wire logic mclk,
   input wire logic ee_req,
   input wire logic ee_we,
   input wire logic [13:0] ee_addr,
   input wire logic [15:0] ee_wdata,
   output logic ee_ack,
   output logic [15:0] ee_rdata
);
   logic [15:0] mem [0:16383];
   int n_rd = 0;
   int n_wr = 0;
   int dly = 0;
   initial ee_ack = 1'b0;
   initial ee_rdata = 16'h0000;
   always @(posedge mclk) begin
      if (ee_req && !ee_ack) begin
         if (dly == 0) dly = 1 + $urandom_range(3);
         dly--;
         if (dly == 0) begin
            ee_ack <= 1'b1;
            if (ee_we) begin
               mem[ee_addr] <= ee_wdata;
               n_wr++; // wear is counted so extra writes show
            end else begin
               ee_rdata <= mem[ee_addr];
               n_rd++;
            end
         end
      end else if (!ee_req && ee_ack) begin
         ee_ack <= 1'b0;
         // released data no longer shows the old word
         ee_rdata <= ~ee_rdata;
      end
   end
endmodule : psr_ee_model

// [test/psr_store_ctrl_tb.sv]
// psr_store_ctrl_tb: random and corner tests of preset reload and backup.
// assumes the eeprom model in psr_ee_model.sv and a ram modelled here.
`timescale 1ns/1ps
module psr_store_ctrl_tb;
   logic mclk = 1'b0, arst_n = 1'b0, ce = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'hF;
   logic [31:0] wb_dat_w = 32'h0, wb_dat_r, q;
   logic scan_start = 1'b0, prog_download = 1'b0, chk_err = 1'b0, scan_hold;
   logic range1_write_busy_flag, range2_write_busy_flag, ram_we, ram_re;
   logic [12:0] ram_addr, n1, n2;
   logic [15:0] ram_wdata, ram_rdata = 16'h0, ee_wdata, ee_rdata;
   logic ee_req, ee_we, ee_ack;
   logic [13:0] ee_addr;
   logic [15:0] ram [0:8191];
   int miscompares = 0, n_compared = 0, cycles = 0, hl = 0, last_hl = 0, n;
   always #50 mclk = ~mclk;
   psr_store_ctrl #(.BKUP_HOLD_CYC(200)) dut_u (.mclk(mclk), .arst_n(arst_n), .ce(ce),
      .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .scan_start(scan_start),
      .prog_download(prog_download), .chk_err(chk_err), .scan_hold(scan_hold),
      .range1_write_busy_flag(range1_write_busy_flag),
      .range2_write_busy_flag(range2_write_busy_flag), .ram_we(ram_we), .ram_re(ram_re),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ee_req(ee_req),
      .ee_we(ee_we), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_ack(ee_ack),
      .ee_rdata(ee_rdata));
   psr_ee_model ee_u (.mclk(mclk), .ee_req(ee_req), .ee_we(ee_we), .ee_addr(ee_addr),
      .ee_wdata(ee_wdata), .ee_ack(ee_ack), .ee_rdata(ee_rdata));
   always @(posedge mclk) begin
      if (ram_we) ram[ram_addr] <= ram_wdata;
      if (ram_re) ram_rdata <= ram[ram_addr];
      cycles++;
      scan_start <= (cycles % 300 == 0);
      if (cycles == 30000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   always @(negedge mclk) begin
      if (ee_req && ee_we) begin
         chk(range1_write_busy_flag, ee_addr < 14'd9 + n1);
         chk(range2_write_busy_flag, ee_addr >= 14'd9 + n1);
      end
      if (scan_hold === 1'b1) hl++;
      else if (hl != 0) begin
         last_hl = hl;
         hl = 0;
      end
   end
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat_w <= d;
      @(posedge mclk);
      while (wb_ack !== 1'b1) @(posedge mclk);
      q = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb
   task automatic wait_ee(input int rd, input int wr);
      while (ee_u.n_rd < rd || ee_u.n_wr < wr || scan_hold !== 1'b0) @(posedge mclk);
      repeat (4) @(posedge mclk);
   endtask : wait_ee
   task automatic scribble();
      for (int i = 0; i < n; i++) ram[13'h07D0 + i] = 16'($urandom);
   endtask : scribble
   task automatic cmp_img();
      for (int i = 0; i < n; i++) chk(ram[13'h07D0 + i], ee_u.mem[9 + i]);
   endtask : cmp_img
   task automatic pulse(input logic dl);
      @(posedge mclk);
      prog_download <= dl;
      chk_err <= !dl;
      @(posedge mclk);
      prog_download <= 1'b0;
      chk_err <= 1'b0;
   endtask : pulse
   task automatic power_up();
      int rd;
      rd = ee_u.n_rd;
      arst_n <= 1'b0;
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      // count is volatile: it must be set while the power-up reload reads the header
      wb(1'b1, 8'h04, {3'h0, n2, 3'h0, n1});
      wb(1'b1, 8'h00, 32'h0000_0003);
      wait_ee(rd + 9 + n, 0);
   endtask : power_up
   task automatic conclude();
      if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   initial begin
      void'($urandom(32'hED12));
      for (int i = 0; i < 16384; i++) ee_u.mem[i] = 16'($urandom);
      n1 = 13'(1 + $urandom_range(3));
      n2 = 13'(1 + $urandom_range(3));
      n = int'(n1 + n2);
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      wait_ee(9, 0);
      chk(ee_u.n_rd, 9); // header only while no presets are set
      wb(1'b1, 8'h04, {3'h0, n2, 3'h0, n1});
      wb(1'b0, 8'h04, 32'h0);
      chk(q, {3'h0, n2, 3'h0, n1});
      wb(1'b0, 8'h0C, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, 8'h00, 32'h0000_0300);
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0); // requests refused without enables
      repeat (400) @(posedge mclk);
      chk(ee_u.n_rd + ee_u.n_wr, 9);
      scribble();
      wb(1'b1, 8'h00, 32'h0000_0103); // single write acts as a one-shot request
      wait_ee(18 + n, 0);
      cmp_img();
      chk(last_hl >= 70 * (9 + n), 1);
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h3);
      scribble();
      pulse(1'b0);
      repeat (20) @(posedge mclk);
      ce <= 1'b0;
      repeat (50) @(posedge mclk);
      chk(scan_hold, 1'b1); // frozen mid-reload while the enable is low
      ce <= 1'b1;
      wb(1'b0, 8'h08, 32'h0);
      chk(q[4:0], 5'h0C); // reload active, scan held, no busy flag
      wait_ee(27 + 2 * n, 0);
      cmp_img();
      scribble();
      wb(1'b1, 8'h00, 32'h0000_0203); // single write acts as a one-shot request
      wait_ee(0, n);
      cmp_img();
      chk(last_hl >= 200 && last_hl < 220, 1);
      chk({range1_write_busy_flag, range2_write_busy_flag}, 2'b00);
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h3);
      wb(1'b1, 8'h00, 32'h0);
      scribble();
      pulse(1'b1);
      wait_ee(0, 2 * n);
      cmp_img();
      chk(ee_u.n_wr, 2 * n);
      scribble();
      power_up();
      cmp_img(); // run-time changes replaced by the backed-up image
      conclude();
   end
endmodule : psr_store_ctrl_tb

// [verilog/psr_ee_port.sv]
// psr_ee_port: four-phase word handshake towards the external EEPROM.
// assumes ee_ack and ee_rdata come from another domain and that ee_rdata
// is stable before ee_ack rises and until ee_req falls.
`timescale 1ns/1ps
module psr_ee_port import psr_pkg::*; (
   // clock, reset and enable
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   // command from the controller
   input wire logic cmd_valid,
   input wire psr_ee_cmd_t cmd,
   output logic done,
   output logic [15:0] rdata,
   // eeprom pins
   output logic ee_req,
   output logic ee_we,
   output logic [13:0] ee_addr,
   output logic [15:0] ee_wdata,
   input wire logic ee_ack,
   input wire logic [15:0] ee_rdata
);
   psr_port_t st_reg, st_next;
   logic ack_s1_reg, ack_s2_reg;
   logic [15:0] rd_s1_reg, rd_s2_reg;
   logic done_next, req_next;
   logic [15:0] rdata_next;
   psr_ee_cmd_t cmd_reg, cmd_next;

   always_comb begin
      st_next = st_reg;
      done_next = 1'b0;
      req_next = ee_req;
      rdata_next = rdata;
      cmd_next = cmd_reg;
      case (st_reg)
         P_IDLE: begin
            if (cmd_valid) begin
               cmd_next = cmd;
               req_next = 1'b1;
               st_next = P_REQ;
            end
         end
         P_REQ: begin
            if (ack_s2_reg) begin
               rdata_next = rd_s2_reg;
               req_next = 1'b0;
               st_next = P_REL;
            end
         end
         P_REL: begin
            // wait for the ack to fall so the next request cannot alias
            if (!ack_s2_reg) begin
               done_next = 1'b1;
               st_next = P_IDLE;
            end
         end
         default: begin
            req_next = 1'b0;
            st_next = P_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= P_IDLE;
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
         rd_s1_reg <= 16'h0000;
         rd_s2_reg <= 16'h0000;
         done <= 1'b0;
         rdata <= 16'h0000;
         ee_req <= 1'b0;
         cmd_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
         ack_s1_reg <= ee_ack;
         ack_s2_reg <= ack_s1_reg;
         rd_s1_reg <= ee_rdata;
         rd_s2_reg <= rd_s1_reg;
         done <= done_next;
         rdata <= rdata_next;
         ee_req <= req_next;
         cmd_reg <= cmd_next;
      end
   end

   assign ee_we = cmd_reg.we;
   assign ee_addr = cmd_reg.addr;
   assign ee_wdata = cmd_reg.data;
endmodule : psr_ee_port

// [verilog/psr_map.svh]
// psr_map.svh: offsets, field positions, reset values and timing counts
// of the preset register store controller.
// assumes a 10 MHz mclk and a 32-bit classic Wishbone register port.
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH
`define PSR_ADR_CTRL 8'h00
`define PSR_ADR_COUNT 8'h04
`define PSR_ADR_STATUS 8'h08
`define PSR_CTRL_INIT_EN 0
`define PSR_CTRL_BKUP_EN 1
`define PSR_CTRL_INIT_REQ 8
`define PSR_CTRL_BKUP_REQ 9
`define PSR_CTRL_RST 1'b0
`define PSR_COUNT_RST 32'h0000_0000
`define PSR_COUNT_MASK 32'h1FFF_1FFF
`define PSR_N1_LSB 0
`define PSR_N2_LSB 16
`define PSR_EXP_BASE 13'h07D0
`define PSR_EXP_LAST 13'h1F3F
`define PSR_EXP_WORDS 14'h1770
`define PSR_HDR_HALF 17
`define PSR_HDR_WORDS ((`PSR_HDR_HALF + 1) / 2)
`define PSR_MCLK_NS 100
`define PSR_LD_NS_PER_KWORD 7000000
`define PSR_LD_WORD_CYC ((`PSR_LD_NS_PER_KWORD / 1000) / `PSR_MCLK_NS)
`define PSR_BKUP_HOLD_NS 200000000
`define PSR_BKUP_HOLD_CYC (`PSR_BKUP_HOLD_NS / `PSR_MCLK_NS)
`define PSR_BKUP_CHUNK 7'h40
`endif

// [verilog/psr_pkg.sv]
// psr_pkg: types shared by the preset register store controller files.
// assumes psr_map.svh supplies all numeric constants.
package psr_pkg;
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_LD_ISSUE = 4'h1,
      S_LD_WAIT = 4'h3,
      S_LD_PACE = 4'h2,
      S_BK_SCAN = 4'h6,
      S_BK_RAM = 4'h7,
      S_BK_ISSUE = 4'h5,
      S_BK_WAIT = 4'h4,
      S_BK_HOLD = 4'hC
   } psr_state_t;
   typedef enum logic [1:0] {
      P_IDLE = 2'h0,
      P_REQ = 2'h1,
      P_REL = 2'h3
   } psr_port_t;
   typedef struct packed {
      logic we;
      logic [13:0] addr;
      logic [15:0] data;
   } psr_ee_cmd_t;
endpackage : psr_pkg

// [verilog/psr_store_ctrl.sv]
// psr_store_ctrl: moves preset register images between EEPROM and RAM.
// assumes the scan engine, RAM and Wishbone master share mclk; the EEPROM
// answers over a four-phase handshake from its own timing domain.
// Functional notes
// - a program download also writes the preset registers into EEPROM.
// - every power-up copies the EEPROM preset image into RAM first; with count reset to zero, only header words are read.
// - run-time changes to preset registers are replaced at next power-up.
// - expansion registers D2000..D7999 always keep data; never cleared at start.
// - a designated initialize request reloads presets from EEPROM like power-up.
// - the initialize request clears itself once the reload is finished.
// - with no initialize bit designated, only a checksum error causes a run-time reload.
// - a designated backup request writes RAM presets into EEPROM, then clears.
// - after a backup, the next power-up loads the newly written values.
// - with no backup bit designated, only a program download performs a backup.
// - range busy flag stays high while that range is written to EEPROM.
// - a program checksum error reloads presets from EEPROM like power-up.
// - reload stretches the scan, about 7 ms per 1000 words read.
// - words read per reload are 8.5 plus the number of preset registers; the code reads 9 header words.
// - backup spreads over scans, each stretched by about 200 ms.
// - expansion register operands take somewhat longer than ordinary ones.
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "psr_map.svh"
module psr_store_ctrl import psr_pkg::*; #(
   parameter int unsigned BKUP_HOLD_CYC = `PSR_BKUP_HOLD_CYC
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   // wishbone slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   // scan engine
   input wire logic scan_start,
   input wire logic prog_download,
   input wire logic chk_err,
   output logic scan_hold,
   output logic range1_write_busy_flag,
   output logic range2_write_busy_flag,
   // working ram
   output logic ram_we,
   output logic ram_re,
   output logic [12:0] ram_addr,
   output logic [15:0] ram_wdata,
   input wire logic [15:0] ram_rdata,
   // eeprom
   output logic ee_req,
   output logic ee_we,
   output logic [13:0] ee_addr,
   output logic [15:0] ee_wdata,
   input wire logic ee_ack,
   input wire logic [15:0] ee_rdata
);
   localparam logic [13:0] HDR = 14'(`PSR_HDR_WORDS);
   localparam logic [6:0] PACE_LAST = 7'(`PSR_LD_WORD_CYC - 1);
   localparam logic [20:0] HOLD_LAST = 21'(BKUP_HOLD_CYC - 1);

   psr_state_t state_reg, state_next;
   logic [13:0] idx_reg, idx_next;
   logic [6:0] pace_reg, pace_next;
   logic [20:0] hold_reg, hold_next;
   logic [6:0] chunk_reg, chunk_next;
   logic lat_reg, lat_next;
   logic pend_ld_reg, pend_ld_next;
   logic pend_dl_reg, pend_dl_next;
   logic scan_hold_next, r1_next, r2_next;
   logic ram_we_next, ram_re_next;
   logic [12:0] ram_addr_next;
   logic [15:0] ram_wdata_next;
   logic cmd_valid_reg, cmd_valid_next;
   psr_ee_cmd_t cmd_reg, cmd_next;
   logic ee_done;
   logic [15:0] ee_rd;
   logic ld_done, bk_done, ld_act, bk_act;
   logic [13:0] tot, ld_last;

   logic init_en_reg, init_en_next;
   logic bk_en_reg, bk_en_next;
   logic init_req_reg, init_req_next;
   logic bk_req_reg, bk_req_next;
   logic [31:0] count_reg, count_next;
   logic ack_next;
   logic [31:0] dat_next;
   logic [12:0] n1;

   // preset words beyond the expansion space are never moved
   function automatic logic [13:0] tot_fn(input logic [12:0] a, input logic [12:0] b);
      logic [13:0] s;
      s = {1'b0, a} + {1'b0, b};
      return (s > `PSR_EXP_WORDS) ? `PSR_EXP_WORDS : s;
   endfunction : tot_fn

   function automatic logic [12:0] ram_at(input logic [13:0] word);
      return `PSR_EXP_BASE + word[12:0];
   endfunction : ram_at

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   assign n1 = count_reg[`PSR_N1_LSB +: 13];
   assign tot = tot_fn(n1, count_reg[`PSR_N2_LSB +: 13]);
   assign ld_last = HDR + tot - 14'h0001;
   assign ld_act = state_reg inside {S_LD_ISSUE, S_LD_WAIT, S_LD_PACE};
   assign bk_act = state_reg inside {S_BK_SCAN, S_BK_RAM, S_BK_ISSUE, S_BK_WAIT, S_BK_HOLD};

   psr_ee_port u_port (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .cmd_valid(cmd_valid_reg),
      .cmd(cmd_reg),
      .done(ee_done),
      .rdata(ee_rd),
      .ee_req(ee_req),
      .ee_we(ee_we),
      .ee_addr(ee_addr),
      .ee_wdata(ee_wdata),
      .ee_ack(ee_ack),
      .ee_rdata(ee_rdata)
   );

   // one engine serves both directions, so the eeprom never sees both
   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      pace_next = pace_reg;
      hold_next = hold_reg;
      chunk_next = chunk_reg;
      lat_next = lat_reg;
      pend_ld_next = pend_ld_reg;
      pend_dl_next = pend_dl_reg;
      scan_hold_next = scan_hold;
      r1_next = range1_write_busy_flag;
      r2_next = range2_write_busy_flag;
      ram_we_next = 1'b0;
      ram_re_next = 1'b0;
      ram_addr_next = ram_addr;
      ram_wdata_next = ram_wdata;
      cmd_valid_next = 1'b0;
      cmd_next = cmd_reg;
      ld_done = 1'b0;
      bk_done = 1'b0;
      if (bk_act && scan_hold && hold_reg != 21'h000000) begin
         hold_next = hold_reg - 21'h000001;
      end
      case (state_reg)
         S_IDLE: begin
            if (pend_ld_reg || init_req_reg) begin
               pend_ld_next = 1'b0;
               idx_next = 14'h0000;
               scan_hold_next = 1'b1;
               state_next = S_LD_ISSUE;
            end else if (pend_dl_reg || bk_req_reg) begin
               pend_dl_next = 1'b0;
               idx_next = 14'h0000;
               state_next = S_BK_SCAN;
            end
         end
         S_LD_ISSUE: begin
            cmd_valid_next = 1'b1;
            cmd_next = '{we: 1'b0, addr: idx_reg, data: 16'h0000};
            state_next = S_LD_WAIT;
         end
         S_LD_WAIT: begin
            if (ee_done) begin
               // header words are read but only preset words reach ram
               if (idx_reg >= HDR) begin
                  ram_we_next = 1'b1;
                  ram_addr_next = ram_at(idx_reg - HDR);
                  ram_wdata_next = ee_rd;
               end
               pace_next = PACE_LAST;
               state_next = S_LD_PACE;
            end
         end
         S_LD_PACE: begin
            if (pace_reg != 7'h00) begin
               pace_next = pace_reg - 7'h01;
            end else if (idx_reg == ld_last) begin
               ld_done = 1'b1;
               scan_hold_next = 1'b0;
               state_next = S_IDLE;
            end else begin
               idx_next = idx_reg + 14'h0001;
               state_next = S_LD_ISSUE;
            end
         end
         S_BK_SCAN: begin
            if (tot == 14'h0000) begin
               bk_done = 1'b1;
               state_next = S_IDLE;
            end else if (scan_start) begin
               scan_hold_next = 1'b1;
               hold_next = HOLD_LAST;
               chunk_next = 7'h00;
               state_next = S_BK_RAM;
            end
         end
         S_BK_RAM: begin
            ram_re_next = 1'b1;
            ram_addr_next = ram_at(idx_reg);
            lat_next = 1'b0;
            r1_next = (idx_reg < {1'b0, n1});
            r2_next = !(idx_reg < {1'b0, n1});
            state_next = S_BK_ISSUE;
         end
         S_BK_ISSUE: begin
            // expansion ram answers a cycle later than ordinary registers
            if (!lat_reg) begin
               lat_next = 1'b1;
            end else begin
               cmd_valid_next = 1'b1;
               cmd_next = '{we: 1'b1, addr: HDR + idx_reg, data: ram_rdata};
               state_next = S_BK_WAIT;
            end
         end
         S_BK_WAIT: begin
            if (ee_done) begin
               idx_next = idx_reg + 14'h0001;
               chunk_next = chunk_reg + 7'h01;
               if (idx_reg + 14'h0001 == {1'b0, n1}) begin
                  r1_next = 1'b0;
               end
               if (idx_reg + 14'h0001 == tot) begin
                  r1_next = 1'b0;
                  r2_next = 1'b0;
                  state_next = S_BK_HOLD;
               end else if (chunk_reg == `PSR_BKUP_CHUNK - 7'h01) begin
                  state_next = S_BK_HOLD;
               end else begin
                  state_next = S_BK_RAM;
               end
            end
         end
         S_BK_HOLD: begin
            if (hold_reg == 21'h000000) begin
               scan_hold_next = 1'b0;
               if (idx_reg == tot) begin
                  bk_done = 1'b1;
                  state_next = S_IDLE;
               end else begin
                  state_next = S_BK_SCAN;
               end
            end
         end
         default: begin
            scan_hold_next = 1'b0;
            r1_next = 1'b0;
            r2_next = 1'b0;
            state_next = S_IDLE;
         end
      endcase
      // late events win over the clear made when a job starts
      if (chk_err) begin
         pend_ld_next = 1'b1;
      end
      if (prog_download) begin
         pend_dl_next = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= S_IDLE;
         idx_reg <= 14'h0000;
         pace_reg <= 7'h00;
         hold_reg <= 21'h000000;
         chunk_reg <= 7'h00;
         lat_reg <= 1'b0;
         pend_ld_reg <= 1'b1;
         pend_dl_reg <= 1'b0;
         scan_hold <= 1'b0;
         range1_write_busy_flag <= 1'b0;
         range2_write_busy_flag <= 1'b0;
         ram_we <= 1'b0;
         ram_re <= 1'b0;
         ram_addr <= 13'h0000;
         ram_wdata <= 16'h0000;
         cmd_valid_reg <= 1'b0;
         cmd_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         pace_reg <= pace_next;
         hold_reg <= hold_next;
         chunk_reg <= chunk_next;
         lat_reg <= lat_next;
         pend_ld_reg <= pend_ld_next;
         pend_dl_reg <= pend_dl_next;
         scan_hold <= scan_hold_next;
         range1_write_busy_flag <= r1_next;
         range2_write_busy_flag <= r2_next;
         ram_we <= ram_we_next;
         ram_re <= ram_re_next;
         ram_addr <= ram_addr_next;
         ram_wdata <= ram_wdata_next;
         cmd_valid_reg <= cmd_valid_next;
         cmd_reg <= cmd_next;
      end
   end

   // register port: ack one cycle after the strobe, unmapped reads give zero
   always_comb begin
      logic wr;
      wr = wb_cyc && wb_stb && wb_we && !wb_ack;
      ack_next = wb_cyc && wb_stb && !wb_ack;
      dat_next = wb_dat_r;
      init_en_next = init_en_reg;
      bk_en_next = bk_en_reg;
      init_req_next = init_req_reg;
      bk_req_next = bk_req_reg;
      count_next = count_reg;
      if (ld_done) begin
         init_req_next = 1'b0;
      end
      if (bk_done) begin
         bk_req_next = 1'b0;
      end
      if (wr && wb_adr == `PSR_ADR_CTRL) begin
         if (wb_sel[0]) begin
            init_en_next = wb_dat_w[`PSR_CTRL_INIT_EN];
            bk_en_next = wb_dat_w[`PSR_CTRL_BKUP_EN];
         end
         if (wb_sel[1] && wb_dat_w[`PSR_CTRL_INIT_REQ]) begin
            init_req_next = 1'b1;
         end
         if (wb_sel[1] && wb_dat_w[`PSR_CTRL_BKUP_REQ]) begin
            bk_req_next = 1'b1;
         end
      end
      if (wr && wb_adr == `PSR_ADR_COUNT) begin
         count_next = merge(count_reg, wb_dat_w, wb_sel) & `PSR_COUNT_MASK;
      end
      // an undesignated request bit cannot hold a request
      init_req_next = init_req_next && init_en_next;
      bk_req_next = bk_req_next && bk_en_next;
      if (ack_next) begin
         case (wb_adr)
            `PSR_ADR_CTRL: dat_next = {22'h000000, bk_req_reg, init_req_reg,
                                       6'h00, bk_en_reg, init_en_reg};
            `PSR_ADR_COUNT: dat_next = count_reg;
            `PSR_ADR_STATUS: dat_next = {20'h00000, state_reg, 3'h0, bk_act, ld_act,
                                         scan_hold, range2_write_busy_flag,
                                         range1_write_busy_flag};
            default: dat_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         init_en_reg <= `PSR_CTRL_RST;
         bk_en_reg <= `PSR_CTRL_RST;
         init_req_reg <= 1'b0;
         bk_req_reg <= 1'b0;
         count_reg <= `PSR_COUNT_RST;
         wb_ack <= 1'b0;
         wb_dat_r <= 32'h0000_0000;
      end else if (ce) begin
         init_en_reg <= init_en_next;
         bk_en_reg <= bk_en_next;
         init_req_reg <= init_req_next;
         bk_req_reg <= bk_req_next;
         count_reg <= count_next;
         wb_ack <= ack_next;
         wb_dat_r <= dat_next;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   property p_busy_excl;
      !(range1_write_busy_flag && range2_write_busy_flag);
   endproperty
   a_busy_excl: assert property (p_busy_excl)
      else $error("both range busy flags high");
   property p_busy_bk;
      (range1_write_busy_flag || range2_write_busy_flag) |-> bk_act;
   endproperty
   a_busy_bk: assert property (p_busy_bk)
      else $error("busy flag high outside backup");
   property p_rw_excl;
      (cmd_valid_reg && cmd_reg.we) |-> !ld_act;
   endproperty
   a_rw_excl: assert property (p_rw_excl)
      else $error("eeprom write issued during reload");
   property p_init_clr;
      $fell(init_req_reg) |-> ($past(ld_done) || !init_en_reg);
   endproperty
   a_init_clr: assert property (p_init_clr)
      else $error("initialize request cleared before reload end");
   property p_no_init;
      !init_en_reg |-> !init_req_reg;
   endproperty
   a_no_init: assert property (p_no_init)
      else $error("initialize request held while undesignated");
   property p_no_bk;
      !bk_en_reg |-> !bk_req_reg;
   endproperty
   a_no_bk: assert property (p_no_bk)
      else $error("backup request held while undesignated");
   property p_ld_hold;
      ld_act |-> scan_hold;
   endproperty
   a_ld_hold: assert property (p_ld_hold)
      else $error("scan not held during reload");
   property p_pace;
      (state_reg == S_LD_WAIT && ee_done && ce) |=> (state_reg == S_LD_PACE)[*8];
   endproperty
   a_pace: assert property (p_pace)
      else $error("reload word pacing too short");
   property p_chk;
      (chk_err && ce) |=> (pend_ld_reg || ld_act);
   endproperty
   a_chk: assert property (p_chk)
      else $error("checksum error did not queue a reload");
   property p_ram_rng;
      ram_we |-> (ram_addr >= `PSR_EXP_BASE && ram_addr <= `PSR_EXP_LAST);
   endproperty
   a_ram_rng: assert property (p_ram_rng)
      else $error("reload wrote outside expansion space");
endmodule : psr_store_ctrl
